// ---- rtl/ssr_map.svh ----
// Operation
// [R1] Stand-alone: message select latched on rising start strobe, one of 256 messages.
// [R2] Start strobe or write strobe accepted only while chip select is low.
// [R3] Stand-alone: low nine ROM address bits on dedicated outputs; unused in slave.
// [R4] Shared port drives high address then receives data; input only in slave.
// [R5] Address latch strobe about 3.13 us; one ROM read cycle about 37.5 us.
// [R6] Address-enable output high while the output address is valid, about 14.1 us.
// [R7] Directory-read flag high while a message start address is fetched.
// [R8] Mode input ignored during synthesis and once in stand-alone mode.
// [R9] Host holds mode select low for slave, high for stand-alone.
// [R10] Slave: host writes each byte typically 31.7 us after data request rises.
// [R11] Active-low busy driven while synthesizing, floated in standby.
// [R12] After synthesis ends, enter standby about 2.9 s later, at most 3 s.
// [R13] After standby escape, busy within 10 us, speech 2.1 to 2.2 ms later; code holds speech until the converter is on, up to 46.5 ms after escape.
// [R14] Converter switches on or off in about 46.5 ms, at most 47 ms.
// [R15] Host escapes standby holding chip select and strobe low at least 350 ns.
// [R16] Standby stops oscillator: first resonator pin low, second high, no output current; code drives 9'h100 until the converter is off.
// [R17] Slave: start strobe unused, host keeps it pulled high.
// [R18] Slave: message select unused, host ties it to ground.
// [R19] Host holds reset low at least 18.5 us.
// [R20] Each sample is a nine-bit converter code; 1ff is full scale.
// [R21] Strobe widths and intervals counted in ticks of a nominal 640 kHz clock.
// [R22] Decoder consumes fetched bytes and emits nine-bit samples at the sample rate.
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_CLK_HZ 125000000
`define SSR_TICK_HZ 640000
`define SSR_TICK_DIV (`SSR_CLK_HZ / `SSR_TICK_HZ)
// Nanoseconds to 640 kHz ticks, nearest; one tick is 1562.5 ns
`define SSR_TICKS(ns) ((64'd0 + (ns)) * 64'd64 + 64'd50000) / 64'd100000
`define SSR_T_ALE_NS 3130
`define SSR_T_AHOLD_NS 3130
`define SSR_T_DRQ_DLY_NS 3130
`define SSR_T_DRQ_NS 7810
`define SSR_T_AEN_NS 14100
`define SSR_T_CYCLE_NS 37500
`define SSR_T_BUSY_NS 6250
`define SSR_T_SPEECH_NS 2100000
`define SSR_T_DAC_NS 46500000
`define SSR_T_STBY_NS 64'd2900000000
`define SSR_SAMPLE_HZ 8000
`define SSR_FIFO_DEPTH 16
`define SSR_END_CODE 8'h00
`define SSR_MID_CODE 9'h100
`define SSR_FULL_CODE 9'h1ff
`define SSR_P_MODE 19
`define SSR_P_CS 18
`define SSR_P_ST 17
`define SSR_P_WR 16
`define SSR_P_MSG 8
`define SSR_P_DATA 0
`endif

// ---- rtl/ssr_pkg.sv ----
package ssr_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_STBY,
    S_DIR,
    S_FETCH,
    S_SLAVE,
    S_DRAIN
  } ssr_state_e;
  typedef logic [7:0] ssr_byte_t;
  typedef logic [8:0] ssr_code_t;
endpackage

// ---- rtl/ssr_fifo.sv ----
`timescale 1ns/1ps
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH so non power-of-two depths work too
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule

// ---- rtl/ssr_ctrl.sv ----
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_ctrl
  import ssr_pkg::*;
#(
  parameter int STBY_TICKS   = int'(`SSR_TICKS(`SSR_T_STBY_NS)),
  parameter int DAC_TICKS    = int'(`SSR_TICKS(`SSR_T_DAC_NS)),
  parameter int SPEECH_TICKS = int'(`SSR_TICKS(`SSR_T_SPEECH_NS)),
  parameter int SAMPLE_TICKS = `SSR_TICK_HZ / `SSR_SAMPLE_HZ,
  parameter int FIFO_DEPTH   = `SSR_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       mode_select_n,
  input  wire logic       chip_select_n,
  input  wire logic       start_strobe_n,
  input  wire logic [7:0] message_select,
  input  wire logic [7:0] addr_data_i,
  output logic      [7:0] addr_data_o,
  output logic            addr_data_oe,
  input  wire logic       addr_valid_or_write_strobe_i,
  output logic            addr_valid_or_write_strobe_o,
  output logic            addr_valid_or_write_strobe_oe,
  output logic      [8:0] low_rom_addr,
  output logic            addr_latch_strobe,
  output logic            directory_read_flag,
  output logic            data_request_n,
  output logic            busy_n_o,
  output logic            busy_n_oe,
  output logic      [8:0] speech_current_out,
  output logic            dac_enable,
  output logic            resonator_in,
  output logic            resonator_out
);
  localparam int DIV    = `SSR_TICK_DIV;
  localparam int ALE_T  = int'(`SSR_TICKS(`SSR_T_ALE_NS));
  localparam int HOLD_T = int'(`SSR_TICKS(`SSR_T_AHOLD_NS));
  localparam int DLY_T  = int'(`SSR_TICKS(`SSR_T_DRQ_DLY_NS));
  localparam int DRQ_T  = int'(`SSR_TICKS(`SSR_T_DRQ_NS));
  localparam int AEN_T  = int'(`SSR_TICKS(`SSR_T_AEN_NS));
  localparam int CYC_T  = int'(`SSR_TICKS(`SSR_T_CYCLE_NS));
  localparam int BUSY_T = int'(`SSR_TICKS(`SSR_T_BUSY_NS));
  localparam int DRQ_S  = ALE_T + DLY_T;
  localparam int DRQ_E  = DRQ_S + DRQ_T - 1;
  localparam int SW     = 20;

  function automatic logic in_win(input logic [7:0] c, input int lo, input int hi);
    return (c >= 8'(lo)) && (c <= 8'(hi));
  endfunction

  ssr_state_e  state_q;
  ssr_state_e  state_d;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic        st_prev_q;
  logic        wr_prev_q;
  logic [7:0]  div_q;
  logic        osc_q;
  logic        init_q;
  logic        sa_q;
  logic [21:0] idle_q;
  logic [15:0] since_q;
  logic [15:0] dcnt_q;
  logic        dac_on_q;
  logic        run_q;
  logic [7:0]  cyc_q;
  logic        pend_q;
  logic        dir_idx_q;
  logic [7:0]  hi_q;
  logic [16:0] addr_q;
  logic [7:0]  scnt_q;
  logic        half_q;
  logic [7:0]  cur_q;
  ssr_code_t   smp_q;

  // Every pin passes two flops before any logic looks at it; left unreset so the
  // mode pin has settled through them by the time it is latched at reset release
  always_ff @(posedge clk) begin
    s1_q <= {mode_select_n, chip_select_n, start_strobe_n,
             addr_valid_or_write_strobe_i, message_select, addr_data_i};
    s2_q <= s1_q;
  end

  logic      md_s;
  logic      cs_s;
  logic      st_s;
  logic      wr_s;
  ssr_byte_t msg_s;
  ssr_byte_t din_s;
  assign md_s  = s2_q[`SSR_P_MODE];
  assign cs_s  = s2_q[`SSR_P_CS];
  assign st_s  = s2_q[`SSR_P_ST];
  assign wr_s  = s2_q[`SSR_P_WR];
  assign msg_s = s2_q[`SSR_P_MSG +: 8];
  assign din_s = s2_q[`SSR_P_DATA +: 8];

  logic tick;
  logic act;
  logic start_acc;
  logic wr_acc;
  logic escape;
  logic cap;
  logic run_go;
  logic run_end;
  logic busy_on;
  logic play;
  logic stk;
  logic pop;
  logic done;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  ssr_byte_t fifo_out_data;

  assign tick      = (div_q == 8'(DIV-1)); // [R21]
  assign act       = (state_q == S_DIR) || (state_q == S_FETCH)
                  || (state_q == S_SLAVE) || (state_q == S_DRAIN);
  assign start_acc = sa_q && st_s && !st_prev_q && !cs_s && (state_q == S_IDLE); // [R1] [R2]
  assign wr_acc    = !sa_q && wr_s && !wr_prev_q && !cs_s; // [R2]
  assign escape    = !cs_s && (sa_q ? !st_s : !wr_s);
  assign cap       = tick && run_q && sa_q && (cyc_q == 8'(DRQ_E));
  assign run_end   = tick && run_q && (cyc_q == (sa_q ? 8'(CYC_T-1) : 8'(DRQ_T-1)));
  assign run_go    = tick && !run_q && ((state_q == S_DIR)
                  || (state_q == S_FETCH && fifo_in_ready)
                  || (state_q == S_SLAVE && fifo_in_ready && !pend_q));
  assign busy_on   = act && (since_q >= 16'(BUSY_T)); // [R13]
  assign play      = busy_on && dac_on_q && (since_q >= 16'(BUSY_T + SPEECH_TICKS));
  assign stk       = tick && play && (scnt_q == 8'(SAMPLE_TICKS-1));
  assign pop       = stk && !half_q && fifo_out_valid;
  assign done      = pop && (fifo_out_data == `SSR_END_CODE);
  assign push      = (cap && state_q == S_FETCH)
                  || (wr_acc && (state_q == S_IDLE || state_q == S_SLAVE));

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (start_acc) begin
          state_d = S_DIR;
        end else if (wr_acc) begin
          state_d = S_SLAVE;
        end else if (tick && idle_q == 22'(STBY_TICKS-1)) begin
          state_d = S_STBY; // [R12]
        end
      end
      S_STBY: begin
        if (escape) begin
          state_d = S_IDLE;
        end
      end
      S_DIR: begin
        if (cap && dir_idx_q) begin
          state_d = S_FETCH;
        end
      end
      S_FETCH: begin
        if (cap && din_s == `SSR_END_CODE) begin
          state_d = S_DRAIN;
        end
      end
      S_SLAVE: begin
        if (done) begin
          state_d = S_IDLE;
        end else if (wr_acc && din_s == `SSR_END_CODE) begin
          state_d = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (done) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // The divider keeps running in standby so the converter can power down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      osc_q <= 1'b0;
    end else begin
      div_q <= tick ? '0 : div_q + 8'h01;
      osc_q <= tick ? !osc_q : osc_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= S_IDLE;
      st_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      idle_q    <= '0;
      since_q   <= '0;
    end else begin
      state_q   <= state_d;
      st_prev_q <= st_s;
      wr_prev_q <= wr_s;
      idle_q    <= (state_q != S_IDLE) ? '0 : idle_q + 22'(tick); // [R12]
      if (!act) begin
        since_q <= '0;
      end else if (tick && since_q != 16'hffff) begin
        since_q <= since_q + 16'h0001;
      end
    end
  end

  // Mode is caught once after reset, then only while idle or in standby in slave mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_q <= 1'b0;
      sa_q   <= 1'b0;
    end else if (!init_q) begin
      init_q <= 1'b1;
      sa_q   <= md_s;
    end else if (!sa_q && !act) begin
      sa_q <= md_s; // [R8]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_on_q <= 1'b0;
      dcnt_q   <= '0;
    end else if (dac_on_q == (state_q != S_STBY)) begin
      dcnt_q <= '0;
    end else if (tick) begin
      if (dcnt_q == 16'(DAC_TICKS-1)) begin
        dac_on_q <= !dac_on_q; // [R14]
        dcnt_q   <= '0;
      end else begin
        dcnt_q <= dcnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q  <= 1'b0;
      cyc_q  <= '0;
      pend_q <= 1'b0;
    end else begin
      if (run_go) begin
        run_q <= 1'b1;
        cyc_q <= '0;
      end else if (run_end) begin
        run_q <= 1'b0;
      end else if (tick && run_q) begin
        cyc_q <= cyc_q + 8'h01; // [R5]
      end
      if (!act || wr_acc) begin
        pend_q <= 1'b0;
      end else if (run_end && !sa_q) begin
        pend_q <= 1'b1;
      end
    end
  end

  // Directory entry of a message is two bytes at twice its number
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q    <= '0;
      hi_q      <= '0;
      dir_idx_q <= 1'b0;
    end else if (start_acc) begin
      addr_q    <= {8'h00, msg_s, 1'b0}; // [R1]
      dir_idx_q <= 1'b0;
    end else if (cap && state_q == S_DIR) begin
      if (!dir_idx_q) begin
        hi_q      <= din_s;
        addr_q    <= addr_q + 17'h00001;
        dir_idx_q <= 1'b1;
      end else begin
        addr_q <= {hi_q, din_s, 1'b0};
      end
    end else if (cap) begin
      addr_q <= addr_q + 17'h00001;
    end
  end

  // Stand-in decoder: two signed steps per byte, saturating at the rails
  logic [3:0]  nib;
  logic [9:0]  sum;
  ssr_code_t   sat;
  assign nib = half_q ? cur_q[3:0] : fifo_out_data[7:4];
  assign sum = {1'b0, smp_q} + {{3{nib[3]}}, nib, 3'b000};
  assign sat = !sum[9] ? sum[8:0] : (nib[3] ? 9'h000 : `SSR_FULL_CODE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scnt_q <= '0;
      half_q <= 1'b0;
      cur_q  <= '0;
      smp_q  <= `SSR_MID_CODE;
    end else if (!play) begin
      scnt_q <= '0;
      half_q <= 1'b0;
      smp_q  <= `SSR_MID_CODE;
    end else if (tick) begin
      scnt_q <= (scnt_q == 8'(SAMPLE_TICKS-1)) ? '0 : scnt_q + 8'h01; // [R22]
      if (stk && (half_q || (pop && !done))) begin
        smp_q  <= sat; // [R20]
        half_q <= !half_q;
        cur_q  <= half_q ? cur_q : fifo_out_data;
      end
    end
  end

  ssr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (din_s),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  logic aen;
  assign aen = sa_q && run_q && in_win(cyc_q, 0, AEN_T-1);
  assign addr_latch_strobe  = sa_q && run_q && in_win(cyc_q, 0, ALE_T-1); // [R5]
  assign addr_data_oe       = sa_q && run_q && in_win(cyc_q, 0, ALE_T+HOLD_T-1); // [R4]
  assign addr_data_o        = addr_q[16:9];
  assign addr_valid_or_write_strobe_o  = aen; // [R6]
  assign addr_valid_or_write_strobe_oe = sa_q;
  assign low_rom_addr       = sa_q ? addr_q[8:0] : 9'h000; // [R3]
  assign directory_read_flag = sa_q && (state_q == S_DIR); // [R7]
  assign data_request_n     = !(run_q && (!sa_q || in_win(cyc_q, DRQ_S, DRQ_E)));
  assign busy_n_o           = !busy_on; // [R11]
  assign busy_n_oe          = (state_q != S_STBY); // [R11]
  assign dac_enable         = dac_on_q;
  assign speech_current_out = dac_on_q ? smp_q : 9'h000; // [R16]
  assign resonator_in       = (state_q == S_STBY) ? 1'b0 : osc_q; // [R16]
  assign resonator_out      = (state_q == S_STBY) ? 1'b1 : !osc_q;

  localparam int A_DRQ_LO = DLY_T * DIV - 1;
  localparam int A_DRQ_HI = DLY_T * DIV + 1;
  localparam int A_BUSY   = (BUSY_T + 1) * DIV;
  logic [15:0] ale_len_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ale_len_q <= '0;
    end else begin
      ale_len_q <= addr_latch_strobe ? ale_len_q + 16'h0001 : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence drq_low_s;
    ##[A_DRQ_LO:A_DRQ_HI] $fell(data_request_n);
  endsequence

  ale_width_a: assert property ($fell(addr_latch_strobe) |-> ale_len_q == 16'(ALE_T*DIV)) // [R5]
    else $error("address latch strobe width wrong");
  drq_after_ale_a: assert property ($fell(addr_latch_strobe) |-> drq_low_s) // [R5]
    else $error("data request not after latch strobe");
  aen_cover_a: assert property ((addr_data_oe || addr_latch_strobe) |-> aen) // [R6]
    else $error("address driven without enable");
  port_slave_a: assert property (!sa_q |-> !addr_data_oe) // [R4]
    else $error("shared port driven in slave mode");
  low_addr_a: assert property (!sa_q |-> low_rom_addr == 9'h000) // [R3]
    else $error("low address active in slave mode");
  msg_latch_a: assert property (start_acc |=> low_rom_addr[8:1] == $past(msg_s)) // [R1]
    else $error("message select not latched");
  dir_flag_a: assert property (start_acc |=> directory_read_flag [*2]) // [R7]
    else $error("directory flag missing");
  start_gate_a: assert property ((state_q == S_IDLE && cs_s) |=> !act) // [R2]
    else $error("strobe accepted without chip select");
  mode_hold_a: assert property ((init_q && (act || sa_q)) |=> $stable(sa_q)) // [R8]
    else $error("mode changed while locked");
  busy_time_a: assert property ($rose(act) |-> ##[1:A_BUSY] !busy_n_o) // [R13]
    else $error("busy late after start");
  stby_busy_a: assert property (state_q == S_STBY |-> !busy_n_oe) // [R11]
    else $error("busy driven in standby");
  stby_enter_a: assert property ((state_q == S_STBY && $past(state_q) == S_IDLE)
                 |-> $past(idle_q) == 22'(STBY_TICKS-1)) // [R12]
    else $error("standby entered at wrong time");
  dac_switch_a: assert property ($changed(dac_on_q) |-> $past(dcnt_q) == 16'(DAC_TICKS-1)) // [R14]
    else $error("converter switch time wrong");
  stby_pins_a: assert property (state_q == S_STBY |-> !resonator_in && resonator_out) // [R16]
    else $error("oscillator pins wrong in standby");
endmodule

// ---- verification/ssr_rom_model.sv ----
`timescale 1ns/1ps
// External speech ROM behind an address latch: the latch takes the high byte
// on the falling edge of the latch strobe, the ROM answers while the address
// is valid and the device has released the shared port.
module ssr_rom_model (
  input  wire logic       clk,
  input  wire logic       addr_latch_strobe,
  input  wire logic       addr_valid,
  input  wire logic       addr_data_oe,
  input  wire logic [7:0] addr_data_o,
  input  wire logic [8:0] low_rom_addr,
  input  wire logic       host_drive,
  input  wire logic [7:0] host_data,
  output logic      [7:0] port_level
);
  logic [7:0]  high_q;
  logic [7:0]  idle_q = 8'h55;
  logic        ale_q;
  logic [16:0] addr_q[$];

  function automatic logic [7:0] rom_byte(input logic [16:0] a);
    case (a)
      17'h00002: return 8'h01;
      17'h00003: return 8'h10;
      17'h00220: return 8'h21;
      17'h00221: return 8'h32;
      17'h001fe: return 8'h02;
      17'h001ff: return 8'h08;
      17'h00410: return 8'h12;
      default:   return 8'h00;
    endcase
  endfunction

  // Every latched access is logged so the bench can check the address order
  always @(posedge clk) begin
    ale_q <= addr_latch_strobe;
    idle_q <= ~idle_q;
    if (ale_q && !addr_latch_strobe) begin
      high_q <= addr_data_o;
      addr_q.push_back({addr_data_o, low_rom_addr});
    end
  end

  // Undriven port toggles so a stale value is never read as data
  assign port_level = addr_data_oe ? addr_data_o :
                      addr_valid   ? rom_byte({high_q, low_rom_addr}) :
                      host_drive   ? host_data : idle_q;
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam int TK = 195;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mode_select_n = 1'b1;
  logic        chip_select_n = 1'b1;
  logic        start_strobe_n = 1'b1;
  logic [7:0]  message_select = 8'h00;
  logic        wr_n = 1'b1;
  logic        host_drive = 1'b0;
  logic [7:0]  host_data = 8'h00;
  logic [7:0]  port_level;
  logic [7:0]  ad_o;
  logic        ad_oe, aen, aen_oe, ale, dir_flag, drq_n, busy_n, busy_oe;
  logic        dac_en, res_in, res_out;
  logic [8:0]  low_addr;
  logic [8:0]  speech;
  logic [8:0]  peak = 9'h000;
  logic        seen_step = 1'b0;
  logic [16:0] want[$];
  int          bad_count = 0;
  int          n_compared = 0;

  ssr_ctrl #(.STBY_TICKS(20), .DAC_TICKS(4), .SPEECH_TICKS(2), .SAMPLE_TICKS(4)) uut (
    .clk(clk), .reset_n(reset_n), .mode_select_n(mode_select_n),
    .chip_select_n(chip_select_n), .start_strobe_n(start_strobe_n),
    .message_select(message_select), .addr_data_i(port_level), .addr_data_o(ad_o),
    .addr_data_oe(ad_oe), .addr_valid_or_write_strobe_i(wr_n),
    .addr_valid_or_write_strobe_o(aen), .addr_valid_or_write_strobe_oe(aen_oe),
    .low_rom_addr(low_addr), .addr_latch_strobe(ale), .directory_read_flag(dir_flag),
    .data_request_n(drq_n), .busy_n_o(busy_n), .busy_n_oe(busy_oe),
    .speech_current_out(speech), .dac_enable(dac_en), .resonator_in(res_in),
    .resonator_out(res_out));

  ssr_rom_model rom (
    .clk(clk), .addr_latch_strobe(ale), .addr_valid(aen & aen_oe), .addr_data_oe(ad_oe),
    .addr_data_o(ad_o), .low_rom_addr(low_addr), .host_drive(host_drive),
    .host_data(host_data), .port_level(port_level));

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dac_en === 1'b1 && speech === 9'h110) seen_step <= 1'b1;
    if (dac_en === 1'b1 && speech > peak) peak <= speech;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic mode, input int n);
    @(posedge clk);
    reset_n <= 1'b0;
    mode_select_n <= mode;
    step(n);
    @(posedge clk);
    reset_n <= 1'b1;
    step(4);
  endtask

  // Strobe held low just over the minimum escape width, select held past it
  task automatic pulse(input logic cs, input logic is_wr, input logic [7:0] d);
    @(posedge clk);
    chip_select_n <= cs;
    host_data <= d;
    host_drive <= is_wr;
    if (is_wr) wr_n <= 1'b0;
    else start_strobe_n <= 1'b0;
    repeat (50) @(posedge clk);
    wr_n <= 1'b1;
    start_strobe_n <= 1'b1;
    repeat (5) @(posedge clk);
    chip_select_n <= 1'b1;
    host_drive <= 1'b0;
    step(1);
  endtask

  task automatic run_message(input logic [7:0] msg);
    int k;
    int n_ale;
    int n_aen;
    rom.addr_q.delete();
    @(posedge clk);
    message_select <= msg;
    pulse(1'b0, 1'b0, 8'h00);
    k = 0;
    while (busy_n !== 1'b0 && k < 5*TK) begin step(1); k++; end
    check(busy_n, 0);
    check(busy_oe, 1);
    check(dir_flag, 1);
    @(posedge clk);
    mode_select_n <= 1'b0;
    step(10);
    check(aen_oe, 1);
    @(posedge clk);
    mode_select_n <= 1'b1;
    k = 0;
    while (ale !== 1'b1 && k < 24*TK) begin step(1); k++; end
    check(ad_oe, 1);
    check(aen, 1);
    n_ale = 0;
    n_aen = 0;
    while (aen === 1'b1 && n_aen < 30*TK) begin
      n_ale += (ale === 1'b1);
      n_aen++;
      step(1);
    end
    check(n_ale, 2*TK);
    check(n_aen, 9*TK);
    check(ad_oe, 0);
    k = 0;
    while (busy_n !== 1'b1 && k < 250*TK) begin step(1); k++; end
    check(busy_n, 1);
    check(rom.addr_q.size(), want.size());
    foreach (want[i]) check(rom.addr_q[i], want[i]);
  endtask

  task automatic run_standby;
    int k;
    k = 0;
    while (busy_oe !== 1'b0 && k < 25*TK) begin step(1); k++; end
    check(busy_oe, 0);
    check(k > 15*TK, 1);
    check({res_in, res_out}, 2'b01);
    step(6*TK);
    check(dac_en, 0);
    check(speech, 0);
    check({res_in, res_out}, 2'b01);
  endtask

  task automatic run_slave;
    int k;
    @(posedge clk);
    message_select <= 8'h00;
    do_reset(1'b0, 2313);
    check(aen_oe, 0);
    check(ad_oe, 0);
    check(low_addr, 0);
    pulse(1'b1, 1'b1, 8'h11);
    step(6*TK);
    check(busy_n, 1);
    pulse(1'b0, 1'b1, 8'h11);
    k = 0;
    while (drq_n !== 1'b0 && k < 3*TK) begin step(1); k++; end
    k = 0;
    while (drq_n === 1'b0 && k < 12*TK) begin step(1); k++; end
    check(k, 5*TK);
    check(busy_n, 0);
    check(dir_flag, 0);
    step(20*TK);
    pulse(1'b0, 1'b1, 8'h00);
    k = 0;
    while (busy_n !== 1'b1 && k < 100*TK) begin step(1); k++; end
    check(busy_n, 1);
  endtask

  // Burst of writes long before speech starts: the FIFO keeps 16, drops the rest.
  // Each byte is one step of 8 up from mid code, so 16 kept bytes end at 9'h180.
  task automatic run_fifo;
    int k;
    repeat (18) pulse(1'b0, 1'b1, 8'h10);
    step(140*TK);
    check(peak, 9'h180);
    pulse(1'b0, 1'b1, 8'h00);
    k = 0;
    while (busy_n !== 1'b1 && k < 20*TK) begin step(1); k++; end
    check(busy_n, 1);
  endtask

  initial begin
    do_reset(1'b1, 10);
    check({busy_n, busy_oe, drq_n, dac_en}, 4'b1110);
    check(speech, 0);
    pulse(1'b1, 1'b0, 8'h00);
    step(6*TK);
    check({busy_n, dir_flag}, 2'b10);
    want = '{17'h00002, 17'h00003, 17'h00220, 17'h00221, 17'h00222};
    run_message(8'h01);
    check(seen_step, 1);
    run_standby;
    want = '{17'h001fe, 17'h001ff, 17'h00410, 17'h00411};
    run_message(8'hff);
    run_slave;
    run_fifo;
    tally_and_finish;
  end

  initial begin
    #790000;
    bad_count++;
    tally_and_finish;
  end
endmodule
